/* hdl/sbr_pkg.sv */
// constants, carrier structs and route states for scan port 2/3 routing
package sbr_pkg;

	// bypass selector codes; the codes above the last valid one name no port
	localparam logic [2:0] SEL_PORT2 = 3'h1;
	localparam logic [2:0] SEL_PORT3 = 3'h2;
	localparam logic [2:0] SEL_LAST_VALID = 3'h5;
	localparam int NUM_PORTS = 2;
	localparam int SYNC_STAGES = 2;
	localparam logic [2:0] PORT_SEL_CODE [0:1] = '{3'h1, 3'h2};

	// bypass enable is active low; its idle level is deasserted
	localparam logic BYPASS_IDLE = 1'h1;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic DEBUG_IDLE = 1'h1;
	localparam logic DEBUG_ACTIVE = 1'h0;
	localparam logic DATA_IDLE = 1'h1;

	// primary scan interface as seen at the gateway's upstream pins
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
		logic auto_write;
	} sbr_primary_type;

	// values the gateway's own port-control logic wants on a port
	typedef struct packed {
		logic tms;
		logic tdo;
		logic auto_write;
	} sbr_gw_type;

	// one local scan port's output pins (or their enables)
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdo;
		logic trst_n;
		logic auto_write;
	} sbr_pins_type;

	localparam sbr_primary_type PRIMARY_RESET = 5'h1F;
	localparam sbr_pins_type PINS_RESET = '{tck: 1'h0, tms: 1'h1, tdo: 1'h1,
		trst_n: 1'h0, auto_write: 1'h1};
	localparam sbr_pins_type PINS_FLOAT_VAL = 5'h1F;
	// enables are active low: all zero means every pin is driven
	localparam sbr_pins_type OE_DRIVE = 5'h00;
	localparam sbr_pins_type OE_FLOAT = 5'h1F;

	typedef enum logic [2:0] {
		ROUTE_GATEWAY = 3'h1,
		ROUTE_BYPASS = 3'h2,
		ROUTE_FLOAT = 3'h4
	} sbr_route_type;

endpackage

/* hdl/sbr_scan_route.sv */
// pin routing for local scan ports 2 and 3: gateway, bypass or float
`timescale 1ns/100ps
`default_nettype none

module sbr_scan_route (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic bypass_mode_n_in,
	input wire logic [2:0] bypass_port_select_in,
	input wire sbr_pkg::sbr_primary_type primary_in,
	input wire logic port2_test_data_in,
	input wire logic port3_test_data_in,
	input wire sbr_pkg::sbr_gw_type gw_port2_in,
	input wire sbr_pkg::sbr_gw_type gw_port3_in,
	output sbr_pkg::sbr_pins_type port2_pins_out,
	output sbr_pkg::sbr_pins_type port2_pins_oe_n_out,
	output logic port2_debug_enable_n_out,
	output sbr_pkg::sbr_pins_type port3_pins_out,
	output sbr_pkg::sbr_pins_type port3_pins_oe_n_out,
	output logic port3_debug_enable_n_out,
	output logic bypass_data_out,
	output logic port2_data_sync_out,
	output logic port3_data_sync_out
);

	localparam int SYNC_W = 11;
	localparam logic [SYNC_W-1:0] SYNC_RESET = {sbr_pkg::BYPASS_IDLE,
		sbr_pkg::SEL_RESET, sbr_pkg::PRIMARY_RESET, sbr_pkg::DATA_IDLE,
		sbr_pkg::DATA_IDLE};

	// routing decision for one port from bypass enable and selector only
	function automatic sbr_pkg::sbr_route_type route_of(
		input logic byp_n,
		input logic [2:0] sel,
		input logic [2:0] code
	);
		sbr_pkg::sbr_route_type r;
		r = sbr_pkg::ROUTE_FLOAT;
		if (byp_n) begin
			r = sbr_pkg::ROUTE_GATEWAY;
		end else if (sel > sbr_pkg::SEL_LAST_VALID) begin
			r = sbr_pkg::ROUTE_FLOAT;
		end else if (sel == code) begin
			r = sbr_pkg::ROUTE_BYPASS;
		end
		return r;
	endfunction

	logic [SYNC_W-1:0] async_bundle;
	logic [SYNC_W-1:0] sync_bundle;
	logic bypass_n_s;
	logic [2:0] select_s;
	sbr_pkg::sbr_primary_type primary_s;
	logic tdi_s [0:1];
	sbr_pkg::sbr_gw_type gw_ctl [0:1];

	// every pin, including the primary test clock, is sampled by clk_in
	assign async_bundle = {bypass_mode_n_in, bypass_port_select_in,
		primary_in, port2_test_data_in, port3_test_data_in};

	sbr_sync #(
		.WIDTH(SYNC_W),
		.RESET_VAL(SYNC_RESET)
	) u_pin_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.async_in(async_bundle),
		.sync_out(sync_bundle)
	);

	assign bypass_n_s = sync_bundle[10];
	assign select_s = sync_bundle[9:7];
	assign primary_s = sync_bundle[6:2];
	assign tdi_s[0] = sync_bundle[1];
	assign tdi_s[1] = sync_bundle[0];
	assign gw_ctl[0] = gw_port2_in;
	assign gw_ctl[1] = gw_port3_in;

	sbr_pkg::sbr_route_type route_ff [0:1];
	sbr_pkg::sbr_route_type nxt_route [0:1];
	sbr_pkg::sbr_pins_type pins_ff [0:1];
	sbr_pkg::sbr_pins_type nxt_pins [0:1];
	sbr_pkg::sbr_pins_type oe_n_ff [0:1];
	sbr_pkg::sbr_pins_type nxt_oe_n [0:1];
	logic de_n_ff [0:1];
	logic nxt_de_n [0:1];

	genvar g;
	generate
		for (g = 0; g < sbr_pkg::NUM_PORTS; g++) begin : g_port
			// no term of the test clock enters the decision
			assign nxt_route[g] = route_of(bypass_n_s, select_s,
				sbr_pkg::PORT_SEL_CODE[g]);

			always_comb begin
				case (nxt_route[g])
					sbr_pkg::ROUTE_GATEWAY: begin
						// clock and reset are synchronised, registered copies of the primary
						nxt_pins[g].tck = primary_s.tck;
						nxt_pins[g].trst_n = primary_s.trst_n;
						nxt_pins[g].tms = gw_ctl[g].tms;
						nxt_pins[g].tdo = gw_ctl[g].tdo;
						nxt_pins[g].auto_write = gw_ctl[g].auto_write;
						nxt_oe_n[g] = sbr_pkg::OE_DRIVE;
						nxt_de_n[g] = sbr_pkg::DEBUG_IDLE;
					end
					sbr_pkg::ROUTE_BYPASS: begin
						nxt_pins[g].tck = primary_s.tck;
						nxt_pins[g].tms = primary_s.tms;
						nxt_pins[g].tdo = primary_s.tdi;
						nxt_pins[g].trst_n = primary_s.trst_n;
						nxt_pins[g].auto_write = primary_s.auto_write;
						nxt_oe_n[g] = sbr_pkg::OE_DRIVE;
						nxt_de_n[g] = sbr_pkg::DEBUG_ACTIVE;
					end
					default: begin
						// floated pins keep a quiet value behind the enable
						nxt_pins[g] = sbr_pkg::PINS_FLOAT_VAL;
						nxt_oe_n[g] = sbr_pkg::OE_FLOAT;
						nxt_de_n[g] = sbr_pkg::DEBUG_IDLE;
					end
				endcase
			end

			// reset state is gateway control with its resting levels
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					route_ff[g] <= sbr_pkg::ROUTE_GATEWAY;
					pins_ff[g] <= sbr_pkg::PINS_RESET;
					oe_n_ff[g] <= sbr_pkg::OE_DRIVE;
					de_n_ff[g] <= sbr_pkg::DEBUG_IDLE;
				end else begin
					route_ff[g] <= nxt_route[g];
					pins_ff[g] <= nxt_pins[g];
					oe_n_ff[g] <= nxt_oe_n[g];
					de_n_ff[g] <= nxt_de_n[g];
				end
			end
		end
	endgenerate

	// returned scan data: the bypassed port's data-in, idle high otherwise
	logic bypass_data_ff;
	logic nxt_bypass_data;
	logic port2_data_ff;
	logic port3_data_ff;

	assign nxt_bypass_data =
		(nxt_route[0] == sbr_pkg::ROUTE_BYPASS) ? tdi_s[0] :
		(nxt_route[1] == sbr_pkg::ROUTE_BYPASS) ? tdi_s[1] :
		sbr_pkg::DATA_IDLE;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bypass_data_ff <= sbr_pkg::DATA_IDLE;
			port2_data_ff <= sbr_pkg::DATA_IDLE;
			port3_data_ff <= sbr_pkg::DATA_IDLE;
		end else begin
			bypass_data_ff <= nxt_bypass_data;
			port2_data_ff <= tdi_s[0];
			port3_data_ff <= tdi_s[1];
		end
	end

	assign port2_pins_out = pins_ff[0];
	assign port2_pins_oe_n_out = oe_n_ff[0];
	assign port2_debug_enable_n_out = de_n_ff[0];
	assign port3_pins_out = pins_ff[1];
	assign port3_pins_oe_n_out = oe_n_ff[1];
	assign port3_debug_enable_n_out = de_n_ff[1];
	assign bypass_data_out = bypass_data_ff;
	// limitation: sampled at 125 MHz, so test clock edges gain up to 3 cycles
	assign port2_data_sync_out = port2_data_ff;
	assign port3_data_sync_out = port3_data_ff;

endmodule

`default_nettype wire

/* hdl/sbr_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module sbr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// meta_ff feeds sync_ff only; nothing else may look at it
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_ff <= RESET_VAL;
			sync_ff <= RESET_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule

`default_nettype wire

/* sim/sbr_chain_model.sv */
// downstream scan chain on one local port
`timescale 1ns/100ps
`default_nettype none
module sbr_chain_model #(
	parameter int LEN = 4
) (
	input wire sbr_pkg::sbr_pins_type pins_in,
	input wire sbr_pkg::sbr_pins_type oe_n_in,
	output logic data_out
);
	logic [LEN-1:0] chain_ff = '1;
	wire logic live = oe_n_in == 5'h00;
	always @(posedge pins_in.tck) begin
		if (live && pins_in.trst_n) begin
			chain_ff <= {chain_ff[LEN-2:0], pins_in.tdo};
		end
	end
	// a released chain shows the inverse so stale data never matches
	assign data_out = live ? chain_ff[LEN-1] : !chain_ff[LEN-1];
endmodule
`default_nettype wire

/* sim/sbr_scan_route_bench.sv */
// self-checking bench for port 2/3 scan routing
`timescale 1ns/100ps
`default_nettype none
module sbr_scan_route_bench;
	logic clk_in = 1'h0;
	logic rst_n = 1'h0;
	logic byp = 1'h1;
	logic [2:0] sel = 3'h0;
	sbr_pkg::sbr_primary_type prim = 5'h1F;
	sbr_pkg::sbr_gw_type gw2 = 3'h7;
	sbr_pkg::sbr_gw_type gw3 = 3'h7;
	sbr_pkg::sbr_pins_type p2, oe2, p3, oe3;
	logic d2, d3, de2, de3, bdat, s2, s3;
	int errors = 0;
	int n_checks = 0;
	sbr_scan_route uut (.clk_in(clk_in), .resetn_in(rst_n),
		.bypass_mode_n_in(byp), .bypass_port_select_in(sel),
		.primary_in(prim), .port2_test_data_in(d2), .port3_test_data_in(d3),
		.gw_port2_in(gw2), .gw_port3_in(gw3), .port2_pins_out(p2),
		.port2_pins_oe_n_out(oe2), .port2_debug_enable_n_out(de2),
		.port3_pins_out(p3), .port3_pins_oe_n_out(oe3),
		.port3_debug_enable_n_out(de3), .bypass_data_out(bdat),
		.port2_data_sync_out(s2), .port3_data_sync_out(s3));
	sbr_chain_model #(.LEN(4)) ch2 (.pins_in(p2), .oe_n_in(oe2), .data_out(d2));
	sbr_chain_model #(.LEN(4)) ch3 (.pins_in(p3), .oe_n_in(oe3), .data_out(d3));
	initial forever #4 clk_in = !clk_in;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic settle;
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic route(input logic b, input logic [2:0] s);
		@(posedge clk_in);
		byp <= b;
		sel <= s;
		settle();
	endtask
	task automatic t_codes;
		for (int i = 0; i < 16; i++) begin
			route(i[3], i[2:0]);
			check(oe2, (i[3] || i[2:0] == 3'h1) ? 8'h00 : 8'h1F);
			check(oe3, (i[3] || i[2:0] == 3'h2) ? 8'h00 : 8'h1F);
			check(de2, (!i[3] && i[2:0] == 3'h1) ? 8'h00 : 8'h01);
			check(de3, (!i[3] && i[2:0] == 3'h2) ? 8'h00 : 8'h01);
		end
		$display("codes done");
	endtask
	task automatic t_paths;
		@(posedge clk_in);
		prim <= 5'h0A;
		route(1'h0, 3'h1);
		check(p2, 8'h0A);
		@(posedge clk_in);
		prim <= 5'h15;
		route(1'h0, 3'h2);
		check(p3, 8'h15);
		$display("paths done");
	endtask
	// selector left at port 2 to show it is ignored in gateway mode
	task automatic t_gateway;
		check(p2, 8'h1F);
		check(p3, 8'h1F);
		@(posedge clk_in);
		prim <= 5'h1D;
		gw2 <= 3'h2;
		gw3 <= 3'h5;
		route(1'h1, 3'h1);
		check(p2, 8'h14);
		check(p3, 8'h19);
		$display("gateway done");
	endtask
	task automatic t_frame(input logic [2:0] s, input logic v);
		@(posedge clk_in);
		prim <= {2'h0, v, 2'h2};
		route(1'h0, s);
		// link clock has a 125 ns period, unrelated to clk_in
		repeat (6) begin
			#62.5ns prim.tck <= 1'h1;
			#62.5ns prim.tck <= 1'h0;
		end
		settle();
		if (s == 3'h1) begin
			check(bdat, v);
			check(s2, v);
		end else begin
			check(bdat, v);
			check(s3, v);
		end
		$display("frame done");
	endtask
	task automatic results;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#20us;
		errors++;
		results();
	end
	initial begin
		repeat (12) @(posedge clk_in);
		rst_n <= 1'h1;
		settle();
		t_gateway();
		t_codes();
		t_paths();
		t_frame(3'h1, 1'h0);
		t_frame(3'h1, 1'h1);
		t_frame(3'h2, 1'h0);
		results();
	end
endmodule
bind sbr_scan_route sbr_scan_route_monitor mon (.*);
`default_nettype wire

/* sim/sbr_scan_route_monitor.sv */
// assertion checker for port 2/3 scan routing
`timescale 1ns/100ps
`default_nettype none
module sbr_scan_route_monitor (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic bypass_mode_n_in,
	input wire logic [2:0] bypass_port_select_in,
	input wire sbr_pkg::sbr_primary_type primary_in,
	input wire logic port2_test_data_in,
	input wire sbr_pkg::sbr_pins_type port2_pins_out,
	input wire sbr_pkg::sbr_pins_type port2_pins_oe_n_out,
	input wire logic port2_debug_enable_n_out,
	input wire sbr_pkg::sbr_pins_type port3_pins_out,
	input wire sbr_pkg::sbr_pins_type port3_pins_oe_n_out,
	input wire logic port3_debug_enable_n_out,
	input wire logic bypass_data_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	wire logic gw = bypass_mode_n_in;
	wire logic b2 = !gw && bypass_port_select_in == 3'h1;
	wire logic b3 = !gw && bypass_port_select_in == 3'h2;
	// four samples cover the two sync stages plus the output flop
	a_port2_bypass: assert property (
		(b2 && $stable(primary_in))[*4] |-> port2_pins_oe_n_out == 5'h00
		&& port2_pins_out == primary_in && !port2_debug_enable_n_out)
		else $error("port 2 bypass wrong");
	a_port3_bypass: assert property (
		(b3 && $stable(primary_in))[*4] |-> port3_pins_oe_n_out == 5'h00
		&& port3_pins_out == primary_in && !port3_debug_enable_n_out)
		else $error("port 3 bypass wrong");
	a_port2_float: assert property (
		(!gw && !b2)[*4] |-> port2_pins_oe_n_out == 5'h1F
		&& port2_debug_enable_n_out) else $error("port 2 not floating");
	a_port3_float: assert property (
		(!gw && !b3)[*4] |-> port3_pins_oe_n_out == 5'h1F
		&& port3_debug_enable_n_out) else $error("port 3 not floating");
	a_gateway_drive: assert property (
		gw[*4] |-> port2_pins_oe_n_out == 5'h00 && port3_pins_oe_n_out ==
		5'h00 && port2_debug_enable_n_out && port3_debug_enable_n_out)
		else $error("gateway mode not driving");
	a_gw_test_reset: assert property (
		(gw && $stable(primary_in))[*4] |->
		port2_pins_out.trst_n == primary_in.trst_n)
		else $error("port 2 reset not following primary");
	a_bypass_data: assert property (
		(b2 && $stable(port2_test_data_in))[*4] |->
		bypass_data_out == port2_test_data_in) else $error("data-in wrong");
	a_route_no_tck: assert property (
		$stable({gw, bypass_port_select_in})[*5] |->
		$stable(port2_pins_oe_n_out) && $stable(port3_pins_oe_n_out))
		else $error("routing moved without a select change");
endmodule
`default_nettype wire
